// ==== logic/ata_command_executor.sv ====
// ata command executor: task file over apb, pio and dma read engines, idle timer
//
// Local design decision: the APB register port.
`timescale 1ns/1ps

// Notes on behaviour
// R1 - master records answers-for-slave, slave-present, diag-passed, own diagnostics in low byte
// R2 - master encodes device-number method in bits 2-1: 01 jumper, 10 csel, 11 other
// R3 - slave clears low byte; master sets bit 0; bit 8 always reads one
// R4 - power word bit 15 marks a valid description; bit 14 stays zero
// R5 - bit 13 set without level-one commands; bit 12 set while they are disabled
// R6 - bits 11-0 of the power word give maximum current in mA
// R7 - EEh returns the 256-word identification block over dma
// R8 - 97h/E3h: busy, enter idle, drop busy, interrupt
// R9 - idle count nonzero arms power-down after count times 5 ms; zero disarms
// R10 - 95h/E1h: busy, idle without touching the power-down timer, interrupt
// R11 - 91h takes sectors per track from count and heads-1 from head nibble
// R12 - DEh and DFh are accepted and do nothing
// R13 - 00h always ends with aborted-command error
// R14 - E4h hands out current sector buffer by pio like a one-sector read
// R15 - C8h reads 1 to 256 sectors by dma, count zero meaning 256
// R16 - dmarq while data ready; host gives dmack and one dior pulse per word
// R17 - dma read interrupts only at full completion or unrecoverable error
// R18 - address holds last sector read, or the failing sector on error
// R19 - dma read aborts while 8-bit transfer mode is enabled
// R20 - 22h/23h: one sector of 256 words then four ecc bytes, unchecked
// R21 - C4h raises data request and interrupt only at each block start; the code raises data request at every sector, interrupt at block start
// R22 - uneven count ends with a partial block of count modulo block size
// R23 - C4h aborts when no block size is set or multiple reads are off
// R24 - reset word bit 15 zero, bit 14 one, bits 12-0 change only at reset
// R25 - a command starts when its opcode is written to the command register
module ata_command_executor
	import ata_cmd_pkg::*;
#(
	parameter int          ADDR_W           = 12,
	parameter int          IDLE_TICK_CYCLES = IDLE_TICK_CYC,
	parameter logic [11:0] MAX_CURRENT_MA   = 12'h064,
	parameter logic        POWER_DESC_VALID = 1'b1,
	parameter logic        NO_PL1_CMDS      = 1'b0
)
(
	input  wire logic              I_CLOCK,
	input  wire logic              I_RESET,
	input  wire logic              I_PSEL,
	input  wire logic              I_PENABLE,
	input  wire logic              I_PWRITE,
	input  wire logic [ADDR_W-1:0] I_PADDR,
	input  wire logic [31:0]       I_PWDATA,
	output logic      [31:0]       O_PRDATA,
	output logic                   O_PREADY,
	output logic                   O_PSLVERR,
	input  wire logic              I_STRAP_SLAVE,
	input  wire logic [1:0]        I_STRAP_METHOD,
	input  wire logic              I_STRAP_ANSWERS,
	input  wire logic              I_STRAP_DASP,
	input  wire logic              I_STRAP_PDIAG,
	input  wire logic              I_STRAP_DIAG_OK,
	input  wire logic              I_DMACK_N,
	input  wire logic              I_DIOR_N,
	output logic                   O_DMARQ,
	output logic      [15:0]       O_DDATA,
	output logic                   O_INTRQ,
	output logic                   O_MEDIA_REQ,
	output logic      [27:0]       O_MEDIA_LBA,
	input  wire logic              I_MEDIA_VALID,
	input  wire logic [15:0]       I_MEDIA_DATA,
	input  wire logic              I_MEDIA_ERR,
	output logic                   O_IDLE,
	output logic                   O_STANDBY
);

	localparam int TW = $clog2(IDLE_TICK_CYCLES + 1);

	exec_e             state_ff;
	logic              pready_ff;
	logic [7:0]        op_ff;
	logic [7:0]        seccnt_ff;
	logic [7:0]        secnum_ff;
	logic [7:0]        cyl_lo_ff;
	logic [7:0]        cyl_hi_ff;
	logic [7:0]        devhead_ff;
	logic [7:0]        error_ff;
	logic              err_ff;
	logic              eight_bit_ff;
	logic              mult_en_ff;
	logic              pl1_dis_ff;
	logic [7:0]        mult_cnt_ff;
	logic [7:0]        spt_ff;
	logic [3:0]        heads_ff;
	logic [15:0]       w93_ff;
	logic              strap_done_ff;
	logic [8:0]        left_ff;
	logic [7:0]        ptr_ff;
	logic [7:0]        blk_pos_ff;
	logic              sec_err_ff;
	logic [31:0]       ecc_ff;
	logic [1:0]        ecc_idx_ff;
	logic              dior_q_ff;
	logic              timer_en_ff;
	logic [7:0]        timer_load_ff;
	logic [7:0]        periods_ff;
	logic [TW-1:0]     tick_ff;
	logic [15:0]       buf_mem [SECTOR_WORDS];

	// apb decode
	wire [3:0]  idx      = I_PADDR[5:2];
	wire        addr_ok  = (I_PADDR[1:0] == 2'b00) && (I_PADDR[ADDR_W-1:6] == '0);
	wire        mapped   = addr_ok && (idx <= IDX_GEOM);
	wire        access   = I_PSEL & I_PENABLE;
	wire        taken    = access & pready_ff;
	wire        wr_take  = taken & I_PWRITE & mapped;
	wire        rd_take  = taken & ~I_PWRITE & mapped;
	wire        hit_data = idx == IDX_DATA;
	wire        hit_cmd  = idx == IDX_COMMAND;
	wire        engaged  = state_ff != ST_IDLE;
	wire        stall    = ~I_PWRITE & hit_data & (state_ff == ST_FETCH);

	// status byte as the host sees it
	ata_status_s status;
	assign status.bsy  = (state_ff == ST_EXEC) || (state_ff == ST_FETCH) || (state_ff == ST_DMA);
	assign status.drdy = 1'b1;
	assign status.df   = 1'b0;
	assign status.dsc  = 1'b1;
	assign status.drq  = (state_ff == ST_PIO) || (state_ff == ST_ECC) || (state_ff == ST_DMA);
	assign status.corr = 1'b0;
	assign status.idx  = 1'b0;
	assign status.err  = err_ff;

	// command decode on the opcode being written
	wire [7:0] new_op   = I_PWDATA[7:0];
	wire       cmd_go   = wr_take & hit_cmd & ~engaged;                               // [R25]
	wire       is_idle  = (new_op == OP_IDLE_A) || (new_op == OP_IDLE_B);
	wire       is_imm   = (new_op == OP_IDLE_IMM_A) || (new_op == OP_IDLE_IMM_B);
	wire       is_long  = (new_op == OP_READ_LONG_A) || (new_op == OP_READ_LONG_B);
	wire       is_fetch = is_long || (new_op == OP_READ_DMA) || (new_op == OP_READ_MULT);
	wire       is_known = is_idle || is_imm || is_fetch || (new_op == OP_INIT_PARAMS)
		|| (new_op == OP_LOCK) || (new_op == OP_UNLOCK) // [R12]
		|| (new_op == OP_READ_BUF) || (new_op == OP_ID_DMA);
	wire       abort_w  = (new_op == OP_NOP) || ~is_known // [R13]
		|| ((new_op == OP_READ_DMA) && eight_bit_ff) // [R19]
		|| ((new_op == OP_READ_MULT) && ((mult_cnt_ff == 8'h00) || ~mult_en_ff)); // [R23]
	wire [8:0] total    = (seccnt_ff == 8'h00) ? 9'(SECTOR_WORDS) : {1'b0, seccnt_ff}; // [R15]

	// transfer progress
	wire       op_long    = (op_ff == OP_READ_LONG_A) || (op_ff == OP_READ_LONG_B);
	wire       word_state = (state_ff == ST_PIO) || (state_ff == ST_DMA);
	wire       dior_fall  = dior_q_ff & ~I_DIOR_N;
	wire       dma_pop    = (state_ff == ST_DMA) & dior_fall & ~I_DMACK_N;          // [R16]
	wire       pio_pop    = ((state_ff == ST_PIO) || (state_ff == ST_ECC)) & rd_take & hit_data;
	wire       pop        = dma_pop | pio_pop;
	wire       word_end   = pop & word_state & (ptr_ff == LAST_WORD);
	wire       sec_end    = (word_end & ~op_long) | (pop & (state_ff == ST_ECC) & (ecc_idx_ff == LAST_ECC));
	wire       last_sec   = (left_ff == 9'd1) | sec_err_ff;
	wire       next_sec   = sec_end & ~last_sec;
	wire       fetch_in   = (state_ff == ST_FETCH) & I_MEDIA_VALID;
	wire       fetch_done = fetch_in & (ptr_ff == LAST_WORD);
	wire       fetch_bad  = sec_err_ff | I_MEDIA_ERR;
	wire [7:0] blk_next   = (blk_pos_ff + 8'd1 == mult_cnt_ff) ? 8'h00 : blk_pos_ff + 8'd1;

	// identification words and outgoing data word
	wire [15:0] w160      = {POWER_DESC_VALID, 1'b0, NO_PL1_CMDS, pl1_dis_ff, MAX_CURRENT_MA}; // [R4] [R5] [R6]
	wire [15:0] ident_w   = (ptr_ff == WORD_RESET_RESULT) ? w93_ff
		: (ptr_ff == WORD_POWER_REQ) ? w160 : 16'h0000;
	wire [15:0] cur_word  = (op_ff == OP_ID_DMA) ? ident_w : buf_mem[ptr_ff];              // [R7]
	wire [7:0]  ecc_byte  = ecc_ff[{ecc_idx_ff, 3'b000} +: 8];

	// interrupt causes
	wire irq_set = (state_ff == ST_EXEC)                                                  // [R8] [R10]
		| (cmd_go & ~abort_w & (new_op == OP_READ_BUF))
		| (fetch_done & (op_ff == OP_READ_DMA) & fetch_bad)                               // [R17]
		| (fetch_done & (op_ff != OP_READ_DMA) & ((op_ff != OP_READ_MULT) | (blk_pos_ff == 8'h00))) // [R21]
		| ((state_ff == ST_DMA) & sec_end & last_sec);                                    // [R17]

	// read data selection
	logic [15:0] rd_val;
	always_comb
	begin
		rd_val = 16'h0000;
		if (hit_data)
			rd_val = (state_ff == ST_ECC) ? {8'h00, ecc_byte} : cur_word;                 // [R14] [R20]
		else if (idx == IDX_FEATURE)
			rd_val = {8'h00, error_ff};
		else if (idx == IDX_SECCNT)
			rd_val = {8'h00, seccnt_ff};
		else if (idx == IDX_SECNUM)
			rd_val = {8'h00, secnum_ff};
		else if (idx == IDX_CYL_LO)
			rd_val = {8'h00, cyl_lo_ff};
		else if (idx == IDX_CYL_HI)
			rd_val = {8'h00, cyl_hi_ff};
		else if (idx == IDX_DEVHEAD)
			rd_val = {8'h00, devhead_ff};
		else if (hit_cmd)
			rd_val = {8'h00, status};
		else if (idx == IDX_CTRL)
			rd_val = {mult_cnt_ff, 2'b00, O_STANDBY, O_IDLE, 1'b0, pl1_dis_ff, mult_en_ff, eight_bit_ff};
		else if (idx == IDX_ID93)
			rd_val = w93_ff;
		else if (idx == IDX_ID160)
			rd_val = w160;
		else if (idx == IDX_GEOM)
			rd_val = {4'h0, heads_ff, spt_ff};
	end

	// apb answer: one wait state, longer for data reads while a sector is still being fetched
	always_ff @(posedge I_CLOCK or posedge I_RESET)
	begin
		if (I_RESET) begin
			pready_ff <= 1'b0;
			O_PREADY  <= 1'b0;
			O_PRDATA  <= 32'h0000_0000;
			O_PSLVERR <= 1'b0;
		end else begin
			pready_ff <= access & ~pready_ff & ~(stall & mapped);
			O_PREADY  <= access & ~pready_ff & ~(stall & mapped);
			O_PRDATA  <= {16'h0000, rd_val};
			O_PSLVERR <= access & ~pready_ff & ~mapped;
		end
	end

	// task file and control register writes; address advances between sectors
	always_ff @(posedge I_CLOCK or posedge I_RESET)
	begin
		if (I_RESET) begin
			seccnt_ff    <= 8'h00;
			secnum_ff    <= 8'h00;
			cyl_lo_ff    <= 8'h00;
			cyl_hi_ff    <= 8'h00;
			devhead_ff   <= 8'h00;
			eight_bit_ff <= 1'b0;
			mult_en_ff   <= 1'b0;
			pl1_dis_ff   <= 1'b0;
			mult_cnt_ff  <= 8'h00;
		end else begin
			if (next_sec)
				{devhead_ff[3:0], cyl_hi_ff, cyl_lo_ff, secnum_ff} <=
					{devhead_ff[3:0], cyl_hi_ff, cyl_lo_ff, secnum_ff} + 28'd1;             // [R18]
			else if (wr_take & ~engaged) begin
				if (idx == IDX_SECCNT)
					seccnt_ff <= I_PWDATA[7:0];
				if (idx == IDX_SECNUM)
					secnum_ff <= I_PWDATA[7:0];
				if (idx == IDX_CYL_LO)
					cyl_lo_ff <= I_PWDATA[7:0];
				if (idx == IDX_CYL_HI)
					cyl_hi_ff <= I_PWDATA[7:0];
				if (idx == IDX_DEVHEAD)
					devhead_ff <= I_PWDATA[7:0];
			end
			if (wr_take & (idx == IDX_CTRL)) begin
				eight_bit_ff <= I_PWDATA[CTRL_EIGHT_BIT];
				mult_en_ff   <= I_PWDATA[CTRL_MULT_EN];
				pl1_dis_ff   <= I_PWDATA[CTRL_PL1_DIS];
				mult_cnt_ff  <= I_PWDATA[CTRL_MULT_CNT_LO +: 8];
			end
		end
	end

	// reset-result word, built once from the straps right after reset release
	always_ff @(posedge I_CLOCK or posedge I_RESET)
	begin
		if (I_RESET) begin
			w93_ff        <= W93_RESET_VALUE;                                               // [R24]
			strap_done_ff <= 1'b0;
		end else if (~strap_done_ff) begin
			strap_done_ff <= 1'b1;
			w93_ff        <= W93_RESET_VALUE;                                               // [R3] [R24]
			if (I_STRAP_SLAVE) begin
				w93_ff[W93_S_PDIAG]           <= I_STRAP_PDIAG;
				w93_ff[W93_S_METHOD_LO +: 2]  <= I_STRAP_METHOD;
			end else begin
				w93_ff[W93_M_ANSWERS]         <= I_STRAP_ANSWERS;                           // [R1]
				w93_ff[W93_M_DASP]            <= I_STRAP_DASP;
				w93_ff[W93_M_PDIAG]           <= I_STRAP_PDIAG;
				w93_ff[W93_M_DIAG_OK]         <= I_STRAP_DIAG_OK;
				w93_ff[W93_M_METHOD_LO +: 2]  <= I_STRAP_METHOD;                            // [R2]
				w93_ff[W93_M_ONE]             <= 1'b1;                                      // [R3]
			end
		end
	end

	// command sequencer
	always_ff @(posedge I_CLOCK or posedge I_RESET)
	begin
		if (I_RESET)
			state_ff <= ST_IDLE;
		else begin
			case (state_ff)
				ST_IDLE:
					if (cmd_go) begin
						if (abort_w)
							state_ff <= ST_EXEC;
						else if (new_op == OP_ID_DMA)
							state_ff <= ST_DMA;                                              // [R7]
						else if (new_op == OP_READ_BUF)
							state_ff <= ST_PIO;                                              // [R14]
						else if (is_fetch)
							state_ff <= ST_FETCH;
						else
							state_ff <= ST_EXEC;
					end
				ST_EXEC:
					state_ff <= ST_IDLE;
				ST_FETCH:
					if (fetch_done) begin
						if (op_ff == OP_READ_DMA)
							state_ff <= fetch_bad ? ST_IDLE : ST_DMA;                       // [R18]
						else
							state_ff <= ST_PIO;
					end
				ST_PIO:
					if (word_end)
						state_ff <= op_long ? ST_ECC : (last_sec ? ST_IDLE : ST_FETCH);  // [R20] [R22]
				ST_ECC:
					if (sec_end)
						state_ff <= ST_IDLE;
				ST_DMA:
					if (sec_end)
						state_ff <= last_sec ? ST_IDLE : ST_FETCH;                          // [R15]
				default:
					state_ff <= ST_IDLE;
			endcase
		end
	end

	// per-command bookkeeping: opcode, sector and block counters, word pointer
	always_ff @(posedge I_CLOCK or posedge I_RESET)
	begin
		if (I_RESET) begin
			op_ff      <= OP_NOP;
			left_ff    <= 9'd0;
			ptr_ff     <= 8'h00;
			blk_pos_ff <= 8'h00;
			ecc_idx_ff <= 2'b00;
		end else if (cmd_go) begin
			op_ff      <= new_op;
			left_ff    <= ((new_op == OP_READ_DMA) || (new_op == OP_READ_MULT)) ? total : 9'd1;
			ptr_ff     <= 8'h00;
			blk_pos_ff <= 8'h00;
			ecc_idx_ff <= 2'b00;
		end else begin
			if (fetch_in | (pop & word_state))
				ptr_ff <= ptr_ff + 8'd1;                                                     // wraps at sector end
			if (pop & (state_ff == ST_ECC))
				ecc_idx_ff <= ecc_idx_ff + 2'd1;                                             // [R20]
			if (next_sec)
				left_ff <= left_ff - 9'd1;
			if (sec_end & (op_ff == OP_READ_MULT))
				blk_pos_ff <= blk_next;                                                      // [R22]
		end
	end

	// sector buffer fill from media, with running check bytes for long reads
	always_ff @(posedge I_CLOCK)
	begin
		if (fetch_in)
			buf_mem[ptr_ff] <= I_MEDIA_DATA;
	end

	always_ff @(posedge I_CLOCK or posedge I_RESET)
	begin
		if (I_RESET) begin
			ecc_ff     <= 32'h0000_0000;
			sec_err_ff <= 1'b0;
		end else begin
			if (cmd_go | next_sec) begin
				ecc_ff     <= 32'h0000_0000;
				sec_err_ff <= 1'b0;
			end else if (fetch_in) begin
				ecc_ff     <= {ecc_ff[30:0], ecc_ff[31]} ^ {16'h0000, I_MEDIA_DATA};        // not verified on read
				sec_err_ff <= fetch_bad;
			end
		end
	end

	// error reporting and host interrupt; a new cause wins over a status read
	always_ff @(posedge I_CLOCK or posedge I_RESET)
	begin
		if (I_RESET) begin
			error_ff <= 8'h00;
			err_ff   <= 1'b0;
			O_INTRQ  <= 1'b0;
		end else begin
			if (cmd_go) begin
				error_ff <= abort_w ? 8'(1 << ERR_ABRT_BIT) : 8'h00;                         // [R13] [R19] [R23]
				err_ff   <= abort_w;
			end else if (fetch_done & fetch_bad) begin
				error_ff <= 8'(1 << ERR_UNC_BIT);
				err_ff   <= 1'b1;
			end
			if (irq_set)
				O_INTRQ <= 1'b1;
			else if (rd_take & hit_cmd)
				O_INTRQ <= 1'b0;
		end
	end

	// drive geometry and power state
	always_ff @(posedge I_CLOCK or posedge I_RESET)
	begin
		if (I_RESET) begin
			spt_ff        <= 8'h00;
			heads_ff      <= 4'h0;
			O_IDLE        <= 1'b0;
			O_STANDBY     <= 1'b0;
			timer_en_ff   <= 1'b0;
			timer_load_ff <= 8'h00;
			periods_ff    <= 8'h00;
			tick_ff       <= '0;
		end else begin
			if (cmd_go & ~abort_w & (new_op == OP_INIT_PARAMS)) begin
				spt_ff   <= seccnt_ff;                                                       // [R11]
				heads_ff <= devhead_ff[3:0];
			end
			if (cmd_go & ~abort_w & is_idle) begin
				timer_en_ff   <= seccnt_ff != 8'h00;                                         // [R9]
				timer_load_ff <= seccnt_ff;
			end
			if (cmd_go & ~abort_w & (is_idle | is_imm))
				O_IDLE <= 1'b1;                                                              // [R8] [R10]
			if (cmd_go) begin
				O_STANDBY  <= 1'b0;
				periods_ff <= 8'h00;
				tick_ff    <= '0;
			end else if (timer_en_ff & O_IDLE & ~O_STANDBY & ~engaged) begin
				if (tick_ff == TW'(IDLE_TICK_CYCLES - 1)) begin
					tick_ff    <= '0;
					periods_ff <= periods_ff + 8'd1;
					if (periods_ff + 8'd1 == timer_load_ff)
						O_STANDBY <= 1'b1;                                                   // [R9]
				end else
					tick_ff <= tick_ff + TW'(1);
			end
		end
	end

	// dma pins and media request
	always_ff @(posedge I_CLOCK or posedge I_RESET)
	begin
		if (I_RESET) begin
			dior_q_ff   <= 1'b1;
			O_DMARQ     <= 1'b0;
			O_DDATA     <= 16'h0000;
			O_MEDIA_REQ <= 1'b0;
			O_MEDIA_LBA <= 28'h000_0000;
		end else begin
			dior_q_ff   <= I_DIOR_N;
			O_DMARQ     <= (state_ff == ST_DMA) & ~sec_end;                                  // [R16]
			O_DDATA     <= cur_word;
			O_MEDIA_REQ <= (state_ff == ST_FETCH) & ~fetch_done;
			O_MEDIA_LBA <= {devhead_ff[3:0], cyl_hi_ff, cyl_lo_ff, secnum_ff};
		end
	end

endmodule : ata_command_executor

// ==== logic/ata_cmd_pkg.sv ====
// constants, opcodes, register map and field layouts of the ata command executor
package ata_cmd_pkg;

	// register indices; the byte address on apb is four times the index
	localparam logic [3:0] IDX_DATA    = 4'h0;
	localparam logic [3:0] IDX_FEATURE = 4'h1;
	localparam logic [3:0] IDX_SECCNT  = 4'h2;
	localparam logic [3:0] IDX_SECNUM  = 4'h3;
	localparam logic [3:0] IDX_CYL_LO  = 4'h4;
	localparam logic [3:0] IDX_CYL_HI  = 4'h5;
	localparam logic [3:0] IDX_DEVHEAD = 4'h6;
	localparam logic [3:0] IDX_COMMAND = 4'h7;
	localparam logic [3:0] IDX_CTRL    = 4'h8;
	localparam logic [3:0] IDX_ID93    = 4'h9;
	localparam logic [3:0] IDX_ID160   = 4'hA;
	localparam logic [3:0] IDX_GEOM    = 4'hB;

	// opcodes handled here
	localparam logic [7:0] OP_NOP         = 8'h00;
	localparam logic [7:0] OP_READ_LONG_A = 8'h22;
	localparam logic [7:0] OP_READ_LONG_B = 8'h23;
	localparam logic [7:0] OP_INIT_PARAMS = 8'h91;
	localparam logic [7:0] OP_IDLE_IMM_A  = 8'h95;
	localparam logic [7:0] OP_IDLE_A      = 8'h97;
	localparam logic [7:0] OP_READ_MULT   = 8'hC4;
	localparam logic [7:0] OP_READ_DMA    = 8'hC8;
	localparam logic [7:0] OP_LOCK        = 8'hDE;
	localparam logic [7:0] OP_UNLOCK      = 8'hDF;
	localparam logic [7:0] OP_IDLE_IMM_B  = 8'hE1;
	localparam logic [7:0] OP_IDLE_B      = 8'hE3;
	localparam logic [7:0] OP_READ_BUF    = 8'hE4;
	localparam logic [7:0] OP_ID_DMA      = 8'hEE;

	// error register bits
	localparam int ERR_ABRT_BIT = 2;
	localparam int ERR_UNC_BIT  = 6;

	// control register fields
	localparam int CTRL_EIGHT_BIT   = 0;
	localparam int CTRL_MULT_EN     = 1;
	localparam int CTRL_PL1_DIS     = 2;
	localparam int CTRL_IDLE_RO     = 4;
	localparam int CTRL_STANDBY_RO  = 5;
	localparam int CTRL_MULT_CNT_LO = 8;

	// reset-result identification word
	localparam logic [7:0]  WORD_RESET_RESULT = 8'h5D;
	localparam logic [15:0] W93_RESET_VALUE   = 16'h4100;
	localparam int          W93_ONE_BIT       = 14;
	localparam int          W93_ALWAYS_ONE    = 8;
	localparam int          W93_M_ANSWERS     = 6;
	localparam int          W93_M_DASP        = 5;
	localparam int          W93_M_PDIAG       = 4;
	localparam int          W93_M_DIAG_OK     = 3;
	localparam int          W93_M_METHOD_LO   = 1;
	localparam int          W93_M_ONE         = 0;
	localparam int          W93_S_PDIAG       = 11;
	localparam int          W93_S_METHOD_LO   = 9;

	// power-requirement identification word
	localparam logic [7:0] WORD_POWER_REQ = 8'hA0;

	// sector geometry of one transfer unit
	localparam int         SECTOR_WORDS = 256;
	localparam logic [7:0] LAST_WORD    = 8'hFF;
	localparam logic [1:0] LAST_ECC     = 2'h3;

	// idle timer base: 5 ms periods at the 20 MHz clock
	localparam int CLOCK_HZ      = 20_000_000;
	localparam int IDLE_TICK_MS  = 5;
	localparam int IDLE_TICK_CYC = CLOCK_HZ / 1000 * IDLE_TICK_MS;

	typedef enum {ST_IDLE, ST_EXEC, ST_FETCH, ST_PIO, ST_ECC, ST_DMA} exec_e;

	// status byte layout
	typedef struct packed {
		logic bsy;
		logic drdy;
		logic df;
		logic dsc;
		logic drq;
		logic corr;
		logic idx;
		logic err;
	} ata_status_s;

endpackage : ata_cmd_pkg

// ==== tb/ata_exec_checker.sv ====
// port assertions for the command executor
`timescale 1ns/1ps
module ata_exec_checker #(parameter int ADDR_W = 12) (
	input wire logic              I_CLOCK, I_RESET, I_PSEL, I_PENABLE, I_PWRITE,
	input wire logic [ADDR_W-1:0] I_PADDR,
	input wire logic [31:0]       O_PRDATA,
	input wire logic              O_PREADY, O_PSLVERR, O_DMARQ, O_INTRQ, O_MEDIA_REQ
);
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (I_RESET);
	// a read answer is on the bus
	wire rd_ok = O_PREADY && !I_PWRITE;
	a_ready_pulse: assert property (O_PREADY |=> !O_PREADY) else $error("ready too long");
	a_ready_access: assert property (O_PREADY |-> I_PSEL && I_PENABLE) else $error("ready outside access");
	a_err_ready: assert property (O_PSLVERR |-> O_PREADY) else $error("error without ready");
	a_unmapped_err: assert property (O_PREADY && I_PADDR[5:2] > 4'hB |-> O_PSLVERR) else $error("no error");
	a_reset_word: assert property (rd_ok && I_PADDR[5:2] == 4'h9 |-> O_PRDATA[15:14] == 2'b01 && O_PRDATA[8])
		else $error("reset word");
	a_power_rsv: assert property (rd_ok && I_PADDR[5:2] == 4'hA |-> !O_PRDATA[14]) else $error("power word");
	a_irq_fetch: assert property ($rose(O_INTRQ) |-> !O_MEDIA_REQ) else $error("irq mid fetch");
	a_dmarq_fetch: assert property (O_DMARQ |-> !O_MEDIA_REQ) else $error("request while fetching");
endmodule : ata_exec_checker

bind ata_command_executor ata_exec_checker #(.ADDR_W(ADDR_W)) i_chk (.I_CLOCK(I_CLOCK), .I_RESET(I_RESET),
	.I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA),
	.O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_DMARQ(O_DMARQ), .O_INTRQ(O_INTRQ), .O_MEDIA_REQ(O_MEDIA_REQ));

// ==== tb/dma_host.sv ====
// host side of the dma link: acknowledges and strobes one word at a time
`timescale 1ns/1ps
module dma_host (
	input  wire logic        i_clk, i_rst, i_dmarq,
	input  wire logic [15:0] i_data,
	input  wire logic [3:0]  i_gap,
	output logic             o_dmack_n, o_dior_n,
	output logic [31:0]      o_cnt, o_sum
);
	logic [3:0] gap_ff;
	// strobe stays high i_gap cycles, so slow hosts are modelled too
	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
		begin
			o_dmack_n <= 1'b1;
			o_dior_n  <= 1'b1;
			o_cnt     <= '0;
			o_sum     <= '0;
			gap_ff    <= '0;
		end
		else
		begin
			o_dmack_n <= !i_dmarq;
			gap_ff    <= (gap_ff == 4'hF) ? gap_ff : gap_ff + 4'h1;
			if (!o_dior_n)
			begin
				o_dior_n <= 1'b1;
				o_cnt    <= o_cnt + 1;
				o_sum    <= o_sum + i_data;
			end
			else if (i_dmarq && !o_dmack_n && gap_ff >= i_gap)
			begin
				o_dior_n <= 1'b0;
				gap_ff   <= '0;
			end
		end
endmodule : dma_host

// ==== tb/tb.sv ====
// self-checking bench: straps, id words, commands, dma and pio reads
`timescale 1ns/1ps
module tb
	import ata_cmd_pkg::*;
;
	logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, slv = 0, ans = 0, dasp = 0, pdg = 0, dok = 0;
	logic        mval = 0, er, prdy, perr, dmarq, dmack_n, dior_n, intrq, mreq, idle, stby;
	logic [1:0]  meth = 2'h1;
	logic [3:0]  gap = 4'h2;
	logic [7:0]  bad = 8'hFF;
	logic [8:0]  widx = '0;
	logic [11:0] paddr = '0;
	logic [15:0] ddata, w93;
	logic [27:0] lba;
	logic [31:0] pwdata = '0, prdata, rd, cnt, sum, c0, s0;
	int          error_cnt = 0, cmp_count = 0, seed = 32'h618c;
	logic [7:0]  ops [8] = '{OP_NOP, OP_LOCK, OP_UNLOCK, OP_INIT_PARAMS, OP_IDLE_A, OP_IDLE_B, OP_IDLE_IMM_A, OP_IDLE_IMM_B};
	initial forever #25 clk = ~clk;
	ata_command_executor #(.IDLE_TICK_CYCLES(10)) i_dut (.I_CLOCK(clk), .I_RESET(rst), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(prdy),
		.O_PSLVERR(perr), .I_STRAP_SLAVE(slv), .I_STRAP_METHOD(meth), .I_STRAP_ANSWERS(ans), .I_STRAP_DASP(dasp),
		.I_STRAP_PDIAG(pdg), .I_STRAP_DIAG_OK(dok), .I_DMACK_N(dmack_n), .I_DIOR_N(dior_n), .O_DMARQ(dmarq),
		.O_DDATA(ddata), .O_INTRQ(intrq), .O_MEDIA_REQ(mreq), .O_MEDIA_LBA(lba), .I_MEDIA_VALID(mval),
		.I_MEDIA_DATA({lba[7:0], widx[7:0]}), .I_MEDIA_ERR(mval && lba[7:0] == bad), .O_IDLE(idle), .O_STANDBY(stby));
	dma_host i_host (.i_clk(clk), .i_rst(rst), .i_dmarq(dmarq), .i_data(ddata), .i_gap(gap),
		.o_dmack_n(dmack_n), .o_dior_n(dior_n), .o_cnt(cnt), .o_sum(sum));
	// media: random pacing, 256 words a request, word = {sector low byte, index}
	always @(posedge clk)
	begin
		mval <= mreq && (widx + mval) < 9'd256 && $random(seed) % 2 != 0;
		widx <= mreq ? widx + mval : 9'd0;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test
	task automatic guard(input logic ok);
		check(ok, 1'b1); // bounded wait ran out
		if (!ok)
			stop_test();
	endtask : guard
	task automatic apb(input logic w, input logic [3:0] idx, input logic [31:0] d);
		int n;
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= {6'h00, idx, 2'h0};
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		for (n = 0; n < 2000 && prdy !== 1'b1; n++)
			@(posedge clk);
		rd = prdata;
		er = perr;
		psel <= 1'b0;
		pen  <= 1'b0;
		guard(n < 2000);
		@(posedge clk);
	endtask : apb
	task automatic cmd(input logic [7:0] op, input logic [7:0] sc, input logic [7:0] a);
		apb(1, IDX_SECCNT, sc);
		apb(1, IDX_SECNUM, a);
		apb(1, IDX_COMMAND, op);
	endtask : cmd
	task automatic fin(input logic e);
		int n;
		for (n = 0; n < 9000 && intrq !== 1'b1; n++)
			@(posedge clk);
		guard(n < 9000);
		apb(0, IDX_COMMAND, 0);
		check(rd[0], e);
	endtask : fin
	task automatic pio(input logic [7:0] l);
		for (int i = 0; i < 256; i++)
		begin
			apb(0, IDX_DATA, 0);
			check(rd, {16'h0, l, i[7:0]});
		end
	endtask : pio
	initial
	begin
		// resets: master with each method code, then slave
		for (int s = 0; s < 4; s++)
		begin
			{ans, dasp, pdg, dok} <= 4'($random(seed));
			meth <= 2'(s % 3 + 1);
			slv  <= (s == 3);
			rst  <= 1'b1;
			repeat (4) @(posedge clk);
			rst <= 1'b0;
			@(posedge clk);
			w93 = slv ? (16'h4100 | {pdg, meth, 9'h000}) : (16'h4101 | {ans, dasp, pdg, dok, meth, 1'b0});
			apb(0, IDX_ID93, 0);
			check(rd, w93);
		end
		// power word with level-one commands enabled, then disabled
		for (int d = 0; d < 2; d++)
		begin
			apb(1, IDX_CTRL, d << CTRL_PL1_DIS);
			apb(0, IDX_ID160, 0);
			check(rd, {1'b1, 1'b0, 1'b0, d[0], 12'h064});
		end
		// no-data commands: only opcode 00h aborts
		apb(1, IDX_DEVHEAD, 8'hA5);
		foreach (ops[k])
		begin
			cmd(ops[k], 8'h3F, 8'h00);
			fin(ops[k] == OP_NOP);
			apb(0, IDX_FEATURE, 0);
			check(rd[ERR_ABRT_BIT], ops[k] == OP_NOP);
		end
		check(idle, 1);
		check(stby, 0);
		apb(0, IDX_GEOM, 0);
		check(rd, 32'h0000_053F);
		// timed idle of three periods
		cmd(OP_IDLE_A, 8'h03, 8'h00);
		fin(0);
		repeat (23) @(posedge clk);
		check(stby, 0);
		repeat (10) @(posedge clk);
		check(stby, 1);
		// dma reads at two host paces, then one hitting a bad sector
		for (int g = 2; g < 5; g++)
		begin
			gap <= 4'(g);
			bad <= (g == 4) ? 8'h21 : 8'hFF;
			c0 = cnt;
			s0 = sum;
			cmd(OP_READ_DMA, 8'h03, 8'h20);
			fin(g == 4);
			if (g < 4)
			begin
				check(cnt - c0, 768);
				check(sum - s0, 65536 * (3 * 32 + 3) + 3 * 32640);
			end
			apb(0, IDX_SECNUM, 0);
			check(rd, (g == 4) ? 8'h21 : 8'h22);
		end
		// refused reads: 8-bit mode, multiple disabled, no block count
		for (int k = 0; k < 3; k++)
		begin
			apb(1, IDX_CTRL, (k == 0) ? 32'h0000_0001 : (k == 1) ? 32'h0000_0200 : 32'h0000_0002);
			cmd((k == 0) ? OP_READ_DMA : OP_READ_MULT, 8'h01, 8'h00);
			fin(1);
		end
		// read multiple: blocks of two, three sectors, partial block last
		apb(1, IDX_CTRL, 32'h0000_0202);
		cmd(OP_READ_MULT, 8'h03, 8'h40);
		for (int b = 0; b < 3; b++)
		begin
			if (b != 1)
				fin(0);
			pio(8'h40 + 8'(b));
			if (b == 1)
				check(intrq, 0);
		end
		// read long then read buffer return the same sector
		cmd(OP_READ_LONG_A, 8'h01, 8'h55);
		fin(0);
		pio(8'h55);
		repeat (4)
		begin
			apb(0, IDX_DATA, 0);
			check(rd[31:8], 0);
		end
		cmd(OP_READ_BUF, 8'h00, 8'h00);
		fin(0);
		pio(8'h55);
		// identify block over dma, unmapped place, reset word unchanged
		c0 = cnt;
		cmd(OP_ID_DMA, 8'h00, 8'h00);
		fin(0);
		check(cnt - c0, 256);
		apb(0, 4'hC, 0);
		check(er, 1);
		apb(0, IDX_ID93, 0);
		check(rd, w93);
		stop_test();
	end
endmodule : tb
